//--- dmrl_pkg.sv
package dmrl_pkg;
   // Mode register addresses
   localparam logic [5:0] DMRL_ADDR_LATENCY = 6'h02;
   localparam logic [5:0] DMRL_ADDR_IO_INVERSION_CONFIG = 6'h03;
   localparam logic [5:0] DMRL_ADDR_REFRESH_TEMP_REPAIR = 6'h04;
   localparam logic [5:0] DMRL_ADDR_MAKER_CODE = 6'h05;

   // Latency register fields
   localparam int DMRL_RL_LSB = 0;
   localparam int DMRL_WL_LSB = 3;
   localparam int DMRL_WLS_BIT = 6;

   // I/O configuration fields
   localparam int DMRL_PUCAL_BIT = 0;
   localparam int DMRL_WPST_BIT = 1;
   localparam int DMRL_PROT_BIT = 2;
   localparam int DMRL_PULLDOWN_DRIVE_STRENGTH_LSB = 3;
   localparam int DMRL_RDINV_BIT = 6;
   localparam int DMRL_WRINV_BIT = 7;

   // Refresh register fields
   localparam int DMRL_SRA_BIT = 3;
   localparam int DMRL_REP_BIT = 4;
   localparam int DMRL_TOFS_LSB = 5;
   localparam int DMRL_TUF_BIT = 7;
   localparam logic [7:0] DMRL_REFRESH_WR_MASK = 8'h78;

   // Reset values
   localparam logic [7:0] DMRL_LATENCY_RESET = 8'h00;
   localparam logic [7:0] DMRL_IO_RESET = 8'h31;
   localparam logic [7:0] DMRL_REFRESH_RESET = 8'h00;
   localparam logic [2:0] DMRL_PULLDOWN_DRIVE_STRENGTH_RESET = 3'h6;
   localparam logic [2:0] DMRL_PULLDOWN_DRIVE_STRENGTH_RSVD_LO = 3'h0;
   localparam logic [2:0] DMRL_PULLDOWN_DRIVE_STRENGTH_RSVD_HI = 3'h7;
   localparam logic [1:0] DMRL_TOFS_RESERVED = 2'h3;
   localparam logic [1:0] DMRL_TOFS_RESET = 2'h0;

   // Extra clocks added to read-to-precharge for 32-beat bursts
   localparam logic [5:0] DMRL_BL32_EXTRA = 6'h08;
   localparam logic [5:0] DMRL_ONE = 6'h01;
endpackage : dmrl_pkg

//--- dmrl_latency_lut.sv
module dmrl_latency_lut
   import dmrl_pkg::*;
(
   // Codes
   input wire logic [2:0] rl_code_i,
   input wire logic [2:0] wl_code_i,
   input wire logic rd_inversion_i,
   input wire logic wl_set_b_i,
   // Latencies in clocks
   output logic [5:0] read_latency_o,
   output logic [5:0] write_latency_o,
   output logic [5:0] write_recovery_clocks_o,
   output logic [5:0] read_to_precharge_clocks_o
);
   // Band tables, row index is the code
   localparam logic [5:0] RL_NOINV [8] = '{6'h06, 6'h0A, 6'h0E, 6'h14, 6'h18, 6'h1C, 6'h20, 6'h24};
   localparam logic [5:0] RL_INV [8] = '{6'h06, 6'h0C, 6'h10, 6'h16, 6'h1C, 6'h20, 6'h24, 6'h28};
   localparam logic [5:0] WL_A [8] = '{6'h04, 6'h06, 6'h08, 6'h0A, 6'h0C, 6'h0E, 6'h10, 6'h12};
   localparam logic [5:0] WL_B [8] = '{6'h04, 6'h08, 6'h0C, 6'h12, 6'h16, 6'h1A, 6'h1E, 6'h22};
   localparam logic [5:0] WRITE_RECOVERY_CLOCKS [8] = '{6'h06, 6'h0A, 6'h10, 6'h14, 6'h18, 6'h1E, 6'h22, 6'h28};
   localparam logic [5:0] READ_TO_PRECHARGE_CLOCKS [8] = '{6'h08, 6'h08, 6'h08, 6'h08, 6'h0A, 6'h0C, 6'h0E, 6'h10};

   // Column selection
   always_comb begin
      read_latency_o = rd_inversion_i ? RL_INV[rl_code_i] : RL_NOINV[rl_code_i]; // [RULE2] [RULE23]
      write_latency_o = wl_set_b_i ? WL_B[wl_code_i] : WL_A[wl_code_i]; // [RULE3]
      write_recovery_clocks_o = WRITE_RECOVERY_CLOCKS[wl_code_i];
      read_to_precharge_clocks_o = READ_TO_PRECHARGE_CLOCKS[rl_code_i];
   end
endmodule : dmrl_latency_lut

//--- dmrl_precharge_timer.sv
module dmrl_precharge_timer
   import dmrl_pkg::*;
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic resetn_i,
   // Start and delay
   input wire logic start_i,
   input wire logic [5:0] delay_i,
   // Precharge start pulse
   output logic fire_o
);
   import dmrl_pkg::*;

   typedef struct packed {
      logic busy;
      logic [5:0] count;
      logic fire;
   } dmrl_timer_t;

   dmrl_timer_t state;
   dmrl_timer_t next_state;

   // Countdown; a new start restarts the count
   always_comb begin
      next_state = state;
      next_state.fire = 1'b0;
      if (start_i) begin
         next_state.busy = 1'b1;
         next_state.count = delay_i;
      end else if (state.busy) begin
         if (state.count <= DMRL_ONE) begin
            next_state.busy = 1'b0;
            next_state.fire = 1'b1;
         end else begin
            next_state.count = state.count - DMRL_ONE;
         end
      end
   end

   // State register
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

   assign fire_o = state.fire;
endmodule : dmrl_precharge_timer

//--- dmrl_mode_regs.sv
// Functional notes
// [RULE1] Controller picks latency codes whose band covers its clock, 10 to 2133 MHz.
// [RULE2] Read latency uses the inversion column when read inversion is enabled.
// [RULE3] Write latency uses set A or set B per the set-select bit.
// [RULE4] Write auto-precharge starts after the programmed write recovery clocks.
// [RULE5] Read auto-precharge starts after the programmed read-to-precharge clocks.
// [RULE6] Burst length 32 adds eight clocks to read-to-precharge.
// [RULE7] I/O bit 0 picks pull-up calibration point; resets to 1.
// [RULE8] I/O bit 1 picks write postamble length; resets to half clock.
// [RULE9] I/O bits 5:3 pull-down strength, reset 110, 000 and 111 reserved.
// [RULE10] Writes update only the copy named by the write set point.
// [RULE11] Device uses only the copy named by the operating set point.
// [RULE12] Controller sets identical pull-up point on both channels before calibration.
// [RULE13] Repair protection bit is sticky, cleared only by power-on reset.
// [RULE14] With protection set, writes of repair entry one are refused.
// [RULE15] Refresh bit 4 enters repair mode on 1, exits on 0.
// [RULE16] Refresh bits 2:0 report the read-only refresh multiplier code.
// [RULE17] Refresh code bit 2 is set above 85 C.
// [RULE18] Update flag sets on refresh code change, cleared by refresh register read.
// [RULE19] Update flag is zero at power-up.
// [RULE20] Only refresh bits 6:3 accept writes.
// [RULE21] Bits 6:5 thermal offset, bit 3 self-refresh abort enable.
// [RULE22] Maker code register is fixed and ignores writes.
// [RULE23] Latency codes 000 to 111 index table rows; reset 000.
// [RULE24] Reserved strength or offset codes are stored but leave behaviour unchanged.
module dmrl_mode_regs
   import dmrl_pkg::*;
#(
   parameter logic [7:0] MAKER_ID = 8'hA5 // arbitrary value
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic resetn_i,
   // Mode register command
   input wire logic mr_write_i,
   input wire logic mr_read_i,
   input wire logic [5:0] mr_addr_i,
   input wire logic [7:0] mr_wdata_i,
   // Set point selects
   input wire logic write_set_point_select_i,
   input wire logic operating_set_point_select_i,
   // Temperature sensor
   input wire logic temp_valid_i,
   input wire logic [2:0] refresh_rate_i,
   // Auto-precharge triggers
   input wire logic write_ap_done_i,
   input wire logic read_ap_done_i,
   input wire logic burst_len_32_i,
   // Read back
   output logic [7:0] mr_rdata_o,
   output logic mr_rvalid_o,
   // Effective configuration
   output logic [5:0] read_latency_o,
   output logic [5:0] write_latency_o,
   output logic [5:0] write_recovery_clocks_o,
   output logic [5:0] read_to_precharge_clocks_o,
   output logic pullup_cal_point_o,
   output logic write_postamble_length_o,
   output logic [2:0] pulldown_drive_strength_o,
   output logic read_inversion_enable_o,
   output logic write_inversion_enable_o,
   output logic repair_protection_o,
   output logic repair_entry_o,
   output logic self_refresh_abort_enable_o,
   output logic [1:0] thermal_offset_o,
   output logic [2:0] refresh_rate_o,
   output logic temp_update_flag_o,
   output logic above_85c_o,
   // Internal precharge starts
   output logic write_precharge_start_o,
   output logic read_precharge_start_o
);
   import dmrl_pkg::*;

   typedef struct packed {
      logic [1:0][7:0] latency;
      logic [1:0][7:0] io_cfg;
      logic [2:0] pulldown_drive_strength_eff0;
      logic [2:0] pulldown_drive_strength_eff1;
      logic protect;
      logic sra;
      logic repair;
      logic [1:0] tofs;
      logic [1:0] tofs_eff;
      logic [2:0] rate;
      logic rate_known;
      logic temp_update_flag;
      logic [7:0] rdata;
      logic rvalid;
   } dmrl_state_t;

   dmrl_state_t state;
   dmrl_state_t next_state;
   logic [7:0] act_latency;
   logic [7:0] act_io;
   logic [2:0] act_pulldown_drive_strength;
   logic [5:0] rtp_base;
   logic [5:0] rtp_eff;
   logic [5:0] write_recovery_clocks;

   // Reserved strength codes 000 and 111
   function automatic logic pulldown_drive_strength_reserved(input logic [2:0] code);
      pulldown_drive_strength_reserved = (code == DMRL_PULLDOWN_DRIVE_STRENGTH_RSVD_LO) || (code == DMRL_PULLDOWN_DRIVE_STRENGTH_RSVD_HI);
   endfunction

   // Active copies
   assign act_latency = state.latency[operating_set_point_select_i]; // [RULE11]
   assign act_io = state.io_cfg[operating_set_point_select_i]; // [RULE11]
   assign act_pulldown_drive_strength = operating_set_point_select_i ? state.pulldown_drive_strength_eff1 : state.pulldown_drive_strength_eff0;

   // Register update
   always_comb begin
      next_state = state;
      next_state.rvalid = 1'b0;
      // Temperature code tracking
      if (temp_valid_i) begin
         next_state.rate = refresh_rate_i; // [RULE16]
         next_state.rate_known = 1'b1;
      end
      // Read clears flag; a same-cycle change sets it again
      if (mr_read_i) begin
         next_state.rvalid = 1'b1;
         case (mr_addr_i)
            DMRL_ADDR_REFRESH_TEMP_REPAIR: begin
               next_state.rdata = {state.temp_update_flag, state.tofs, state.repair, state.sra, state.rate};
               next_state.temp_update_flag = 1'b0; // [RULE18]
            end
            DMRL_ADDR_MAKER_CODE: next_state.rdata = MAKER_ID; // [RULE22]
            default: next_state.rdata = 8'h00;
         endcase
      end
      if (temp_valid_i && state.rate_known && (refresh_rate_i != state.rate)) begin
         next_state.temp_update_flag = 1'b1; // [RULE18]
      end
      if (mr_write_i) begin
         case (mr_addr_i)
            DMRL_ADDR_LATENCY: begin
               next_state.latency[write_set_point_select_i] = mr_wdata_i; // [RULE10]
            end
            DMRL_ADDR_IO_INVERSION_CONFIG: begin
               next_state.io_cfg[write_set_point_select_i] = mr_wdata_i; // [RULE10]
               if (!pulldown_drive_strength_reserved(mr_wdata_i[DMRL_PULLDOWN_DRIVE_STRENGTH_LSB +: 3])) begin
                  if (write_set_point_select_i) begin
                     next_state.pulldown_drive_strength_eff1 = mr_wdata_i[DMRL_PULLDOWN_DRIVE_STRENGTH_LSB +: 3]; // [RULE24]
                  end else begin
                     next_state.pulldown_drive_strength_eff0 = mr_wdata_i[DMRL_PULLDOWN_DRIVE_STRENGTH_LSB +: 3]; // [RULE24]
                  end
               end
               if (mr_wdata_i[DMRL_PROT_BIT]) begin
                  next_state.protect = 1'b1; // [RULE13]
               end
            end
            DMRL_ADDR_REFRESH_TEMP_REPAIR: begin
               // Bits outside 6:3 ignored
               next_state.sra = mr_wdata_i[DMRL_SRA_BIT]; // [RULE20] [RULE21]
               next_state.tofs = mr_wdata_i[DMRL_TOFS_LSB +: 2]; // [RULE21]
               if (mr_wdata_i[DMRL_TOFS_LSB +: 2] != DMRL_TOFS_RESERVED) begin
                  next_state.tofs_eff = mr_wdata_i[DMRL_TOFS_LSB +: 2]; // [RULE24]
               end
               if (!(mr_wdata_i[DMRL_REP_BIT] && state.protect)) begin
                  next_state.repair = mr_wdata_i[DMRL_REP_BIT]; // [RULE14] [RULE15]
               end
            end
            default: begin
               // Maker code and unknown addresses unchanged
            end
         endcase
      end
   end

   // State register
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         state <= '0;
         state.latency <= {DMRL_LATENCY_RESET, DMRL_LATENCY_RESET}; // [RULE23]
         state.io_cfg <= {DMRL_IO_RESET, DMRL_IO_RESET}; // [RULE7] [RULE8] [RULE9]
         state.pulldown_drive_strength_eff0 <= DMRL_PULLDOWN_DRIVE_STRENGTH_RESET;
         state.pulldown_drive_strength_eff1 <= DMRL_PULLDOWN_DRIVE_STRENGTH_RESET;
         state.tofs <= DMRL_TOFS_RESET;
         state.tofs_eff <= DMRL_TOFS_RESET;
         state.protect <= 1'b0; // [RULE13]
         state.temp_update_flag <= 1'b0; // [RULE19]
      end else begin
         state <= next_state;
      end
   end

   // Latency lookup
   dmrl_latency_lut u_lut (
      .rl_code_i(act_latency[DMRL_RL_LSB +: 3]),
      .wl_code_i(act_latency[DMRL_WL_LSB +: 3]),
      .rd_inversion_i(act_io[DMRL_RDINV_BIT]),
      .wl_set_b_i(act_latency[DMRL_WLS_BIT]),
      .read_latency_o(read_latency_o),
      .write_latency_o(write_latency_o),
      .write_recovery_clocks_o(write_recovery_clocks),
      .read_to_precharge_clocks_o(rtp_base)
   );

   // Burst length 32 extension
   assign rtp_eff = burst_len_32_i ? rtp_base + DMRL_BL32_EXTRA : rtp_base; // [RULE6]

   // Auto-precharge timers
   dmrl_precharge_timer u_wr_timer (
      .clk_i(clk_i),
      .resetn_i(resetn_i),
      .start_i(write_ap_done_i),
      .delay_i(write_recovery_clocks), // [RULE4]
      .fire_o(write_precharge_start_o)
   );

   dmrl_precharge_timer u_rd_timer (
      .clk_i(clk_i),
      .resetn_i(resetn_i),
      .start_i(read_ap_done_i),
      .delay_i(rtp_eff), // [RULE5]
      .fire_o(read_precharge_start_o)
   );

   // Outputs
   assign write_recovery_clocks_o = write_recovery_clocks;
   assign read_to_precharge_clocks_o = rtp_eff;
   assign pullup_cal_point_o = act_io[DMRL_PUCAL_BIT]; // [RULE7]
   assign write_postamble_length_o = act_io[DMRL_WPST_BIT]; // [RULE8]
   assign pulldown_drive_strength_o = act_pulldown_drive_strength; // [RULE9]
   assign read_inversion_enable_o = act_io[DMRL_RDINV_BIT];
   assign write_inversion_enable_o = act_io[DMRL_WRINV_BIT];
   assign repair_protection_o = state.protect;
   assign repair_entry_o = state.repair;
   assign self_refresh_abort_enable_o = state.sra;
   assign thermal_offset_o = state.tofs_eff;
   assign refresh_rate_o = state.rate;
   assign temp_update_flag_o = state.temp_update_flag;
   assign above_85c_o = state.rate[2]; // [RULE17]
   assign mr_rdata_o = state.rdata;
   assign mr_rvalid_o = state.rvalid;
endmodule : dmrl_mode_regs

//--- dmrl_ctrl_model.sv
module dmrl_ctrl_model (
   // Clock
   input wire logic clk_i,
   // Mode register command
   output logic mr_write_o,
   output logic mr_read_o,
   output logic [5:0] mr_addr_o,
   output logic [7:0] mr_wdata_o
);
   timeunit 1ns;
   timeprecision 1ps;

   // Idle command lines
   initial begin
      mr_write_o = 1'b0;
      mr_read_o = 1'b0;
      mr_addr_o = 6'h00;
      mr_wdata_o = 8'h00;
   end

   // One-cycle command; callers pick in-band codes and equal pull-up points
   task automatic issue(input logic wr, input logic [5:0] a, input logic [7:0] d);
      @(negedge clk_i);
      mr_write_o = wr;
      mr_read_o = ~wr;
      mr_addr_o = a;
      mr_wdata_o = d;
      @(negedge clk_i);
      mr_write_o = 1'b0;
      mr_read_o = 1'b0;
      // Released lines stop showing the old value
      mr_addr_o = ~a;
      mr_wdata_o = ~d;
   endtask
endmodule // dmrl_ctrl_model

//--- dmrl_mode_regs_properties.sv
module dmrl_mode_regs_properties
   import dmrl_pkg::*;
#(
   parameter logic [7:0] MAKER_ID = 8'hA5 // arbitrary value
) (
   // Watched ports
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire logic mr_write_i,
   input wire logic mr_read_i,
   input wire logic [5:0] mr_addr_i,
   input wire logic [7:0] mr_wdata_i,
   input wire logic temp_valid_i,
   input wire logic [2:0] refresh_rate_i,
   input wire logic write_ap_done_i,
   input wire logic read_ap_done_i,
   input wire logic [7:0] mr_rdata_o,
   input wire logic mr_rvalid_o,
   input wire logic [5:0] write_recovery_clocks_o,
   input wire logic [5:0] read_to_precharge_clocks_o,
   input wire logic repair_protection_o,
   input wire logic repair_entry_o,
   input wire logic self_refresh_abort_enable_o,
   input wire logic [1:0] thermal_offset_o,
   input wire logic [2:0] refresh_rate_o,
   input wire logic temp_update_flag_o,
   input wire logic above_85c_o,
   input wire logic write_precharge_start_o,
   input wire logic read_precharge_start_o
);
   timeunit 1ns;
   timeprecision 1ps;

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!resetn_i);
   logic seen;

   // Marks that the first sensor sample has landed
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         seen <= 1'b0;
      end else if (temp_valid_i) begin
         seen <= 1'b1;
      end
   end

   // Refresh register write and read
   wire logic rf_wr = mr_write_i && (mr_addr_i == DMRL_ADDR_REFRESH_TEMP_REPAIR);
   wire logic rf_rd = mr_read_i && (mr_addr_i == DMRL_ADDR_REFRESH_TEMP_REPAIR);

   a_read_answer: assert property (mr_rvalid_o == $past(mr_read_i))
      else $error("read answer timing wrong");
   a_maker_fixed: assert property (mr_read_i && mr_addr_i == DMRL_ADDR_MAKER_CODE
      |=> mr_rdata_o == MAKER_ID) else $error("maker code wrong");
   a_tuf_sets: assert property (seen && temp_valid_i && refresh_rate_i != refresh_rate_o
      |=> temp_update_flag_o && refresh_rate_o == $past(refresh_rate_i)) else $error("flag not set");
   a_tuf_clears: assert property (rf_rd && !temp_valid_i |=> !temp_update_flag_o)
      else $error("flag not cleared by read");
   a_hot_bit: assert property (temp_valid_i |=> above_85c_o == $past(refresh_rate_i[2]))
      else $error("hot indication wrong");
   a_protect_sticky: assert property (repair_protection_o |=> repair_protection_o)
      else $error("protection dropped");
   a_repair_refused: assert property (repair_protection_o && !repair_entry_o && rf_wr
      |=> !repair_entry_o) else $error("repair entered while protected");
   a_abort_written: assert property (rf_wr
      |=> self_refresh_abort_enable_o == $past(mr_wdata_i[DMRL_SRA_BIT])) else $error("abort bit");
   a_offset_reserved: assert property (rf_wr && mr_wdata_i[6:5] == DMRL_TOFS_RESERVED
      |=> $stable(thermal_offset_o)) else $error("reserved offset took effect");
   a_write_recovery: assert property (write_ap_done_i && write_recovery_clocks_o == 6'h06
      ##1 !write_ap_done_i [*6] |=> write_precharge_start_o) else $error("write precharge late");
   a_read_precharge: assert property (read_ap_done_i && read_to_precharge_clocks_o == 6'h08
      ##1 !read_ap_done_i [*8] |=> read_precharge_start_o) else $error("read precharge late");

   // Main scenarios reached
   c_flag_read: cover property (mr_rvalid_o && mr_rdata_o[7]);
   c_wr_fire: cover property (write_precharge_start_o);
   c_protected_write: cover property (repair_protection_o && rf_wr);
endmodule // dmrl_mode_regs_properties

//--- tb_dmrl_mode_regs.sv
module tb_dmrl_mode_regs;
   timeunit 1ns;
   timeprecision 1ps;
   import dmrl_pkg::*;
   logic clk_i = 1'b0, resetn_i = 1'b0;
   logic write_set_point_select_i = 1'b0, operating_set_point_select_i = 1'b0;
   logic temp_valid_i = 1'b0, write_ap_done_i = 1'b0, read_ap_done_i = 1'b0, burst_len_32_i = 1'b0;
   logic [2:0] refresh_rate_i = 3'h0, pulldown_drive_strength_o, refresh_rate_o, r, prev;
   logic mr_write_i, mr_read_i, mr_rvalid_o, pullup_cal_point_o, write_postamble_length_o;
   logic read_inversion_enable_o, write_inversion_enable_o, repair_protection_o, repair_entry_o;
   logic self_refresh_abort_enable_o, temp_update_flag_o, above_85c_o;
   logic write_precharge_start_o, read_precharge_start_o;
   logic [5:0] mr_addr_i, read_latency_o, write_latency_o, write_recovery_clocks_o;
   logic [5:0] read_to_precharge_clocks_o;
   logic [7:0] mr_wdata_i, mr_rdata_o;
   logic [1:0] thermal_offset_o;
   logic [15:0] lfsr = 16'h5BCA;
   logic [7:0] exp_q[$];
   int error_cnt = 0, comparisons = 0;
   int rl_a[8] = '{6, 10, 14, 20, 24, 28, 32, 36};
   int rl_b[8] = '{6, 12, 16, 22, 28, 32, 36, 40};
   int wl_a[8] = '{4, 6, 8, 10, 12, 14, 16, 18};
   int wl_b[8] = '{4, 8, 12, 18, 22, 26, 30, 34};
   int write_recovery_clocks[8] = '{6, 10, 16, 20, 24, 30, 34, 40};
   int read_to_precharge_clocks[8] = '{8, 8, 8, 8, 10, 12, 14, 16};

   dmrl_mode_regs uut (.*);
   dmrl_ctrl_model ctl (.clk_i(clk_i), .mr_write_o(mr_write_i), .mr_read_o(mr_read_i),
      .mr_addr_o(mr_addr_i), .mr_wdata_o(mr_wdata_i));

   // Clock
   always #2.5 clk_i = ~clk_i;

   task automatic chk(input logic [7:0] s, input logic [7:0] e);
      comparisons++;
      if (s !== e) begin
         error_cnt++;
         $display("unexpected at %0t: saw %h expected %h", $time, s, e);
      end
   endtask

   task automatic end_of_test();
      if (error_cnt == 0 && comparisons > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // Read answers against the oldest expectation
   always @(negedge clk_i) begin
      if (mr_rvalid_o === 1'b1) begin
         chk(mr_rdata_o, exp_q.size() > 0 ? exp_q.pop_front() : 8'hXX);
      end
   end

   task automatic rd(input logic [5:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      ctl.issue(1'b0, a, 8'h00);
   endtask

   task automatic io_chk(input logic [7:0] e);
      chk({1'b0, pullup_cal_point_o, write_postamble_length_o, pulldown_drive_strength_o,
         read_inversion_enable_o, write_inversion_enable_o}, e);
   endtask

   task automatic rf_chk(input logic [7:0] e);
      chk({temp_update_flag_o, thermal_offset_o, repair_entry_o, self_refresh_abort_enable_o,
         refresh_rate_o}, e);
   endtask

   // Auto-precharge start measured from the taking edge
   task automatic timer(input logic rdp, input int n);
      int k;
      k = 0;
      @(negedge clk_i);
      write_ap_done_i = ~rdp;
      read_ap_done_i = rdp;
      @(negedge clk_i);
      write_ap_done_i = 1'b0;
      read_ap_done_i = 1'b0;
      do begin
         @(posedge clk_i);
         #1;
         k++;
      end while (k < 100 && (rdp ? read_precharge_start_o : write_precharge_start_o) !== 1'b1);
      chk(8'(k), 8'(n));
      if (k == 100) end_of_test();
   endtask

   task automatic sense(input logic [2:0] v);
      @(negedge clk_i);
      temp_valid_i = 1'b1;
      refresh_rate_i = v;
      @(negedge clk_i);
      temp_valid_i = 1'b0;
      refresh_rate_i = ~v;
   endtask

   initial begin
      repeat (6) @(negedge clk_i);
      resetn_i = 1'b1;
      io_chk(8'h58);
      chk(8'(read_latency_o), 8'h06);
      timer(1'b0, 6);
      timer(1'b1, 8);
      rd(DMRL_ADDR_REFRESH_TEMP_REPAIR, 8'h00);
      ctl.issue(1'b1, DMRL_ADDR_MAKER_CODE, lfsr[7:0]);
      rd(DMRL_ADDR_MAKER_CODE, 8'hA5);
      rd(6'h3F, 8'h00);
      for (int c = 0; c < 8; c++) begin
         for (int v = 0; v < 2; v++) begin
            burst_len_32_i = v[0];
            ctl.issue(1'b1, DMRL_ADDR_IO_INVERSION_CONFIG, v[0] ? 8'h71 : 8'h31);
            ctl.issue(1'b1, DMRL_ADDR_LATENCY, {1'b0, v[0], c[2:0], c[2:0]});
            chk(8'(read_latency_o), 8'(v ? rl_b[c] : rl_a[c]));
            chk(8'(write_latency_o), 8'(v ? wl_b[c] : wl_a[c]));
            chk(8'(write_recovery_clocks_o), 8'(write_recovery_clocks[c]));
            chk(8'(read_to_precharge_clocks_o), 8'(read_to_precharge_clocks[c] + 8 * v));
         end
      end
      timer(1'b0, 40);
      timer(1'b1, 24);
      burst_len_32_i = 1'b0;
      timer(1'b1, 16);
      write_set_point_select_i = 1'b1;
      ctl.issue(1'b1, DMRL_ADDR_LATENCY, 8'h1B);
      chk(8'(read_latency_o), 8'h28);
      operating_set_point_select_i = 1'b1;
      @(negedge clk_i);
      chk(8'(read_latency_o), 8'h14);
      ctl.issue(1'b1, DMRL_ADDR_IO_INVERSION_CONFIG, 8'h8A);
      io_chk(8'h25);
      ctl.issue(1'b1, DMRL_ADDR_IO_INVERSION_CONFIG, 8'h3A);
      io_chk(8'h24);
      ctl.issue(1'b1, DMRL_ADDR_REFRESH_TEMP_REPAIR, 8'hDF);
      rf_chk(8'h58);
      ctl.issue(1'b1, DMRL_ADDR_REFRESH_TEMP_REPAIR, 8'h60);
      rf_chk(8'h40);
      ctl.issue(1'b1, DMRL_ADDR_REFRESH_TEMP_REPAIR, 8'h20);
      rf_chk(8'h20);
      ctl.issue(1'b1, DMRL_ADDR_IO_INVERSION_CONFIG, 8'h35);
      ctl.issue(1'b1, DMRL_ADDR_REFRESH_TEMP_REPAIR, 8'h30);
      rf_chk(8'h20);
      ctl.issue(1'b1, DMRL_ADDR_IO_INVERSION_CONFIG, 8'h31);
      chk(8'(repair_protection_o), 8'h01);
      sense(3'h3);
      prev = 3'h3;
      rf_chk(8'h23);
      for (int i = 0; i < 4; i++) begin
         lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
         r = (lfsr[2:0] == prev) ? lfsr[2:0] ^ 3'h4 : lfsr[2:0];
         sense(r);
         prev = r;
         chk(8'(above_85c_o), 8'(r[2]));
         rf_chk({5'h14, r});
         rd(DMRL_ADDR_REFRESH_TEMP_REPAIR, {5'h14, r});
         rd(DMRL_ADDR_REFRESH_TEMP_REPAIR, {5'h04, r});
      end
      @(negedge clk_i);
      resetn_i = 1'b0;
      @(negedge clk_i);
      resetn_i = 1'b1;
      chk(8'(repair_protection_o), 8'h00);
      repeat (2) @(negedge clk_i);
      chk(8'(exp_q.size()), 8'h00);
      end_of_test();
   end
endmodule // tb_dmrl_mode_regs

bind dmrl_mode_regs dmrl_mode_regs_properties #(.MAKER_ID(MAKER_ID)) u_props (.*);
